// File: design/dkq_defs.vh
// Constants for the cipher key, chain vector and queue front end
//------------------------------------------------------------------
// Notes on behaviour
// - Key byte low bit is parity, masked off.
// - Key two kept as left, right halves.
// - Key three kept as left, right halves.
// - Chain vector used only in chaining mode.
// - Software seeds vector; engine updates after block.
// - Input queue, eight words, processor or DMA.
// - Output queue, eight words, processor or DMA.
// - Order clear: first word in is left.
// - Order set: first word in is right.
// - Order clear: first word out is left.
// - Order set: first word out is right.
// - Space and ready flags at four or two.
// - Input full flag at eight words held.
// - Single mode ignores keys two and three.
// - Control bit six selects chaining mode.
//------------------------------------------------------------------
`ifndef DKQ_DEFS_VH
`define DKQ_DEFS_VH

// Register byte offsets
`define DKQ_OFS_CTRL 6'h00
`define DKQ_OFS_STAT 6'h04
`define DKQ_OFS_IEN 6'h08
`define DKQ_OFS_ISTAT 6'h0c
`define DKQ_OFS_ICLR 6'h10
`define DKQ_OFS_K2L 6'h14
`define DKQ_OFS_K2R 6'h18
`define DKQ_OFS_K3L 6'h1c
`define DKQ_OFS_K3R 6'h20
`define DKQ_OFS_IVL 6'h24
`define DKQ_OFS_IVR 6'h28
`define DKQ_OFS_INQ 6'h2c
`define DKQ_OFS_OUTQ 6'h30

// Control word fields
`define DKQ_C_RUN 0
`define DKQ_C_IN_DMA 1
`define DKQ_C_OUT_DMA 2
`define DKQ_C_ORDER 3
`define DKQ_C_DECRYPT 4
`define DKQ_C_TRIPLE 5
`define DKQ_C_CHAIN 6
`define DKQ_C_THRESH 7
`define DKQ_C_FLUSH 9
`define DKQ_CTRL_RST 10'h000

// Status, interrupt enable and interrupt status fields
`define DKQ_S_IDLE 0
`define DKQ_S_SPACE 4
`define DKQ_S_IN_EMPTY 5
`define DKQ_S_IN_FULL 6
`define DKQ_S_READY 8
`define DKQ_S_OUT_EMPTY 9
`define DKQ_S_OUT_FULL 10
`define DKQ_INT_MASK 11'h111

// Queue thresholds and key parity mask
`define DKQ_THR_WIDE 4'h4
`define DKQ_THR_NARROW 4'h2
`define DKQ_KEY_MASK 32'hfefe_fefe

`endif

// File: design/dkq_front.v
// Key, chain vector and data queue front end of a block cipher engine
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`include "dkq_defs.vh"

module dkq_front #(
	parameter DEPTH = 8,
	parameter AW = 3
) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Avalon-MM slave
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Interrupt
	output reg irq,
	// DMA input channel
	output reg dma_in_req,
	input wire dma_in_valid,
	input wire [31:0] dma_in_data,
	// DMA output channel
	output reg dma_out_req,
	output reg dma_out_valid,
	output reg [31:0] dma_out_data,
	input wire dma_out_pop,
	// Cipher core
	output reg core_start,
	output reg [63:0] core_block,
	output reg core_decrypt,
	output reg core_triple,
	output reg [63:0] core_key_two,
	output reg [63:0] core_key_three,
	input wire core_done,
	input wire [63:0] core_result
);

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	function [31:0] key_mask;
		input [31:0] half;
		begin
			key_mask = half & `DKQ_KEY_MASK;
		end
	endfunction

	function [3:0] thresh;
		input sel;
		begin
			thresh = sel ? `DKQ_THR_NARROW : `DKQ_THR_WIDE;
		end
	endfunction

	localparam [3:0] DEPTH_W = DEPTH[3:0];

	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_POP1 = 6'h02;
	localparam [5:0] S_POP2 = 6'h04;
	localparam [5:0] S_RUN = 6'h08;
	localparam [5:0] S_PUT1 = 6'h10;
	localparam [5:0] S_PUT2 = 6'h20;

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	reg [9:0] ctrl_reg;
	reg [10:0] ien_reg;
	reg [10:0] istat_reg;
	reg [31:0] k2l_reg;
	reg [31:0] k2r_reg;
	reg [31:0] k3l_reg;
	reg [31:0] k3r_reg;
	reg [31:0] ivl_reg;
	reg [31:0] ivr_reg;
	reg [31:0] in_mem [0:DEPTH-1];
	reg [31:0] out_mem [0:DEPTH-1];
	reg [AW-1:0] in_wp_reg;
	reg [AW-1:0] in_rp_reg;
	reg [AW:0] in_cnt_reg;
	reg [AW-1:0] out_wp_reg;
	reg [AW-1:0] out_rp_reg;
	reg [AW:0] out_cnt_reg;
	reg [5:0] state_reg;
	reg [5:0] state_next;
	reg [31:0] first_reg;
	reg [63:0] in_blk_reg;
	reg [63:0] res_reg;
	reg space_q_reg;
	reg ready_q_reg;

	wire bus_wr = avs_write & ~avs_waitrequest;
	wire bus_rd = avs_read & ~avs_waitrequest;
	wire order = ctrl_reg[`DKQ_C_ORDER];
	wire chain = ctrl_reg[`DKQ_C_CHAIN];
	wire decrypt = ctrl_reg[`DKQ_C_DECRYPT];
	wire in_dma = ctrl_reg[`DKQ_C_IN_DMA];
	wire out_dma = ctrl_reg[`DKQ_C_OUT_DMA];
	wire flush = ctrl_reg[`DKQ_C_FLUSH];

	//------------------------------------------------------------------
	// Queue levels and flags
	//------------------------------------------------------------------
	wire [3:0] in_used = {{(3 - AW){1'b0}}, in_cnt_reg};
	wire [3:0] out_used = {{(3 - AW){1'b0}}, out_cnt_reg};
	wire [3:0] in_free = DEPTH_W - in_used;
	wire [3:0] out_free = DEPTH_W - out_used;
	wire in_full = (in_used == DEPTH_W);
	wire out_full = (out_used == DEPTH_W);
	wire space_flag = (in_free >= thresh(ctrl_reg[`DKQ_C_THRESH]));
	wire ready_flag = (out_used >= thresh(ctrl_reg[`DKQ_C_THRESH]));
	wire idle = (state_reg == S_IDLE);

	// Queue fill from the selected source only; a full queue drops the word
	wire cpu_push = bus_wr & (avs_address == `DKQ_OFS_INQ) & ~in_dma;
	wire dma_push = dma_in_valid & in_dma;
	wire in_push = (cpu_push | dma_push) & ~in_full;
	wire cpu_pop = bus_rd & (avs_address == `DKQ_OFS_OUTQ) & ~out_dma;
	wire dma_pop = dma_out_pop & dma_out_valid & out_dma;
	wire out_pop = (cpu_pop | dma_pop) & (out_used != 4'h0);
	wire [31:0] in_word = in_dma ? dma_in_data : avs_writedata;

	reg in_pop;
	reg out_push;
	reg [31:0] out_word;
	reg blk_done;

	//------------------------------------------------------------------
	// Block sequencer
	//------------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		in_pop = 1'b0;
		out_push = 1'b0;
		out_word = 32'h0000_0000;
		blk_done = 1'b0;
		case (state_reg)
			S_IDLE: begin
				// Room for the result is reserved before anything is taken
				if (ctrl_reg[`DKQ_C_RUN] & ~flush & (in_used >= 4'h2) & (out_free >= 4'h2)) begin
					state_next = S_POP1;
				end
			end
			S_POP1: begin
				in_pop = 1'b1;
				state_next = S_POP2;
			end
			S_POP2: begin
				in_pop = 1'b1;
				state_next = S_RUN;
			end
			S_RUN: begin
				if (core_done) begin
					state_next = S_PUT1;
				end
			end
			S_PUT1: begin
				out_push = 1'b1;
				out_word = order ? res_reg[31:0] : res_reg[63:32];
				state_next = S_PUT2;
			end
			S_PUT2: begin
				out_push = 1'b1;
				out_word = order ? res_reg[63:32] : res_reg[31:0];
				blk_done = 1'b1;
				state_next = S_IDLE;
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	// Block assembled from the two popped words
	wire [63:0] pair_blk = order ? {in_mem[in_rp_reg], first_reg} :
		{first_reg, in_mem[in_rp_reg]};
	wire [63:0] iv_blk = {ivl_reg, ivr_reg};
	wire use_iv = chain;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			first_reg <= 32'h0000_0000;
			in_blk_reg <= 64'h0000_0000_0000_0000;
			res_reg <= 64'h0000_0000_0000_0000;
			core_start <= 1'b0;
			core_block <= 64'h0000_0000_0000_0000;
		end else begin
			state_reg <= state_next;
			core_start <= 1'b0;
			if (state_reg == S_POP1) begin
				first_reg <= in_mem[in_rp_reg];
			end
			if (state_reg == S_POP2) begin
				in_blk_reg <= pair_blk;
				core_start <= 1'b1;
				// Encrypt side of chaining mixes the vector in before the core
				if (use_iv & ~decrypt) begin
					core_block <= pair_blk ^ iv_blk;
				end else begin
					core_block <= pair_blk;
				end
			end
			if ((state_reg == S_RUN) & core_done) begin
				if (use_iv & decrypt) begin
					res_reg <= core_result ^ iv_blk;
				end else begin
					res_reg <= core_result;
				end
			end
		end
	end

	//------------------------------------------------------------------
	// Queues
	//------------------------------------------------------------------
	always @(posedge core_clk) begin
		if (in_push) begin
			in_mem[in_wp_reg] <= in_word;
		end
		if (out_push) begin
			out_mem[out_wp_reg] <= out_word;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			in_wp_reg <= {AW{1'b0}};
			in_rp_reg <= {AW{1'b0}};
			in_cnt_reg <= {(AW + 1){1'b0}};
			out_wp_reg <= {AW{1'b0}};
			out_rp_reg <= {AW{1'b0}};
			out_cnt_reg <= {(AW + 1){1'b0}};
		end else if (flush) begin
			in_wp_reg <= {AW{1'b0}};
			in_rp_reg <= {AW{1'b0}};
			in_cnt_reg <= {(AW + 1){1'b0}};
			out_wp_reg <= {AW{1'b0}};
			out_rp_reg <= {AW{1'b0}};
			out_cnt_reg <= {(AW + 1){1'b0}};
		end else begin
			if (in_push) begin
				in_wp_reg <= in_wp_reg + 1'b1;
			end
			if (in_pop) begin
				in_rp_reg <= in_rp_reg + 1'b1;
			end
			if (in_push & ~in_pop) begin
				in_cnt_reg <= in_cnt_reg + 1'b1;
			end else if (in_pop & ~in_push) begin
				in_cnt_reg <= in_cnt_reg - 1'b1;
			end
			if (out_push) begin
				out_wp_reg <= out_wp_reg + 1'b1;
			end
			if (out_pop) begin
				out_rp_reg <= out_rp_reg + 1'b1;
			end
			if (out_push & ~out_pop) begin
				out_cnt_reg <= out_cnt_reg + 1'b1;
			end else if (out_pop & ~out_push) begin
				out_cnt_reg <= out_cnt_reg - 1'b1;
			end
		end
	end

	//------------------------------------------------------------------
	// Registers and bus answer
	//------------------------------------------------------------------
	wire [10:0] status = {out_full, (out_used == 4'h0), ready_flag, 1'b0, in_full,
		(in_used == 4'h0), space_flag, 3'b000, idle};
	// Events: block finished, space flag rising, ready flag rising
	wire [10:0] events = {2'b00, ready_flag & ~ready_q_reg, 3'b000,
		space_flag & ~space_q_reg, 3'b000, blk_done};
	wire [10:0] clr = (bus_wr & (avs_address == `DKQ_OFS_ICLR)) ?
		avs_writedata[10:0] : 11'h000;
	wire [63:0] next_iv = decrypt ? in_blk_reg : res_reg;
	wire iv_upd = (state_reg == S_PUT2) & chain;

	reg [31:0] rd_val;
	always @* begin
		case (avs_address)
			`DKQ_OFS_CTRL: rd_val = {22'h0_0000, ctrl_reg};
			`DKQ_OFS_STAT: rd_val = {21'h0_0000, status};
			`DKQ_OFS_IEN: rd_val = {21'h0_0000, ien_reg};
			`DKQ_OFS_ISTAT: rd_val = {21'h0_0000, istat_reg};
			`DKQ_OFS_K2L: rd_val = k2l_reg;
			`DKQ_OFS_K2R: rd_val = k2r_reg;
			`DKQ_OFS_K3L: rd_val = k3l_reg;
			`DKQ_OFS_K3R: rd_val = k3r_reg;
			`DKQ_OFS_IVL: rd_val = ivl_reg;
			`DKQ_OFS_IVR: rd_val = ivr_reg;
			`DKQ_OFS_OUTQ: rd_val = (out_dma | (out_used == 4'h0)) ? 32'h0000_0000 :
				out_mem[out_rp_reg];
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			ctrl_reg <= `DKQ_CTRL_RST;
			ien_reg <= 11'h000;
			istat_reg <= 11'h000;
			k2l_reg <= 32'h0000_0000;
			k2r_reg <= 32'h0000_0000;
			k3l_reg <= 32'h0000_0000;
			k3r_reg <= 32'h0000_0000;
			ivl_reg <= 32'h0000_0000;
			ivr_reg <= 32'h0000_0000;
			// Empty queue has space: starting high avoids a false event
			space_q_reg <= 1'b1;
			ready_q_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			// One wait cycle, then a single ready cycle per request
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_readdata <= rd_val;
			end
			space_q_reg <= space_flag;
			ready_q_reg <= ready_flag;
			// Set wins over a clear in the same cycle
			istat_reg <= ((istat_reg & ~clr) | events) & `DKQ_INT_MASK;
			irq <= |(istat_reg & ien_reg);
			// Flush request clears itself after one cycle
			ctrl_reg[`DKQ_C_FLUSH] <= 1'b0;
			if (bus_wr) begin
				case (avs_address)
					`DKQ_OFS_CTRL: ctrl_reg <= avs_writedata[9:0];
					`DKQ_OFS_IEN: ien_reg <= avs_writedata[10:0] & `DKQ_INT_MASK;
					`DKQ_OFS_K2L: k2l_reg <= avs_writedata;
					`DKQ_OFS_K2R: k2r_reg <= avs_writedata;
					`DKQ_OFS_K3L: k3l_reg <= avs_writedata;
					`DKQ_OFS_K3R: k3r_reg <= avs_writedata;
					`DKQ_OFS_IVL: ivl_reg <= avs_writedata;
					`DKQ_OFS_IVR: ivr_reg <= avs_writedata;
					default: ;
				endcase
			end
			// Engine update of the vector overrides a software write
			if (iv_upd) begin
				ivl_reg <= next_iv[63:32];
				ivr_reg <= next_iv[31:0];
			end
		end
	end

	//------------------------------------------------------------------
	// Core side and DMA handshakes
	//------------------------------------------------------------------
	wire triple = ctrl_reg[`DKQ_C_TRIPLE];
	wire [3:0] out_left = out_used - {3'b000, out_pop};

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			core_decrypt <= 1'b0;
			core_triple <= 1'b0;
			core_key_two <= 64'h0000_0000_0000_0000;
			core_key_three <= 64'h0000_0000_0000_0000;
			dma_in_req <= 1'b0;
			dma_out_req <= 1'b0;
			dma_out_valid <= 1'b0;
			dma_out_data <= 32'h0000_0000;
		end else begin
			core_decrypt <= decrypt;
			core_triple <= triple;
			// Keys two and three are hidden from the core in single mode
			if (triple) begin
				core_key_two <= {key_mask(k2l_reg), key_mask(k2r_reg)};
				core_key_three <= {key_mask(k3l_reg), key_mask(k3r_reg)};
			end else begin
				core_key_two <= 64'h0000_0000_0000_0000;
				core_key_three <= 64'h0000_0000_0000_0000;
			end
			dma_in_req <= space_flag & in_dma & ~flush;
			dma_out_req <= ready_flag & out_dma & ~flush;
			// Valid drops for a cycle after each pop so the head word refreshes
			dma_out_valid <= out_dma & ~flush & ~dma_pop & (out_left != 4'h0);
			dma_out_data <= out_mem[out_rp_reg];
		end
	end

endmodule

// File: tb/dkq_core_model.sv
// Cipher core stand-in: answers each block after a short or long delay
module dkq_core_model #(
	parameter logic [63:0] XK = 64'h0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Block in
	input wire logic core_start,
	input wire logic [63:0] core_block,
	// Result out
	output logic core_done,
	output logic [63:0] core_result,
	// Seen by the bench
	output logic [63:0] seen_block,
	output logic [7:0] n_blocks
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	logic busy;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			core_done <= 1'b0;
			core_result <= 64'h0;
			seen_block <= 64'h0;
			n_blocks <= 8'h00;
			cnt <= 4'h0;
			busy <= 1'b0;
		end else begin
			core_done <= 1'b0;
			// Result is only good with done; otherwise it keeps moving
			core_result <= ~core_result;
			if (core_start) begin
				busy <= 1'b1;
				cnt <= n_blocks[0] ? 4'h1 : 4'h9;
				seen_block <= core_block;
				n_blocks <= n_blocks + 8'h01;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
				if (cnt == 4'h1) begin
					busy <= 1'b0;
					core_done <= 1'b1;
					core_result <= seen_block ^ XK;
				end
			end
		end
	end
endmodule

// File: tb/dkq_front_properties.sv
// Port-level checker for the key, vector and queue front end
module dkq_front_properties (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Register bus
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	// Irq and output channel
	input wire irq,
	input wire dma_out_pop,
	input wire dma_out_valid,
	// Cipher core side
	input wire core_start,
	input wire [63:0] core_block,
	input wire core_triple,
	input wire [63:0] core_key_two,
	input wire [63:0] core_key_three
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);

	//----------------------------------------
	// Assertions
	//----------------------------------------
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer not after one wait cycle");
	AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_K2_PARITY: assert property ((core_key_two & {8{8'h01}}) == 64'h0)
		else $error("key two parity bit reaches core");
	AST_K3_PARITY: assert property ((core_key_three & {8{8'h01}}) == 64'h0)
		else $error("key three parity bit reaches core");
	AST_SINGLE_KEYS: assert property (!core_triple |-> core_key_two == 64'h0
		&& core_key_three == 64'h0) else $error("keys two and three used in single mode");
	AST_NO_RESTART: assert property (core_start |=> !core_start [*3])
		else $error("block restarted too soon");
	AST_BLOCK_HOLD: assert property (core_start |=> $stable(core_block) [*3])
		else $error("block changed while core busy");
	AST_OUT_POP: assert property (dma_out_pop && dma_out_valid |=> !dma_out_valid)
		else $error("output head not consumed by pop");

	// Main scenarios reached
	COV_START: cover property (core_start);
	COV_POP: cover property (dma_out_pop && dma_out_valid);
	COV_IRQ: cover property ($rose(irq));
endmodule

bind dkq_front dkq_front_properties chk_u (.*);

// File: tb/testbench.sv
// Self-checking bench for the key, vector and queue front end
`include "dkq_defs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] XK = 64'h5a5a_5a5a_0f0f_0f0f;
	logic core_clk, rst, avs_read, avs_write, dma_in_valid, dma_out_pop;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, dma_in_data;
	wire [31:0] avs_readdata, dma_out_data;
	wire avs_waitrequest, irq, dma_in_req, dma_out_req, dma_out_valid;
	wire core_start, core_decrypt, core_triple, core_done;
	wire [63:0] core_block, core_key_two, core_key_three, core_result, seen_block;
	wire [7:0] n_blocks;
	int n_errors, comparisons;

	dkq_front dut_u (.*);
	dkq_core_model #(.XK(XK)) core_u (.*);

	initial begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus access; holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (i >= 50) n_errors++;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask

	// Feeds one block by processor writes and checks what reaches the core
	task automatic blk(input logic [31:0] a, input logic [31:0] b, input logic [63:0] e);
		logic [7:0] p;
		logic [31:0] q;
		int i;
		p = n_blocks;
		wr(`DKQ_OFS_INQ, a);
		wr(`DKQ_OFS_INQ, b);
		i = 0;
		while (n_blocks === p && i < 50) begin
			@(posedge core_clk);
			i++;
		end
		chk(seen_block, e);
		i = 0;
		do begin
			bus(1'b0, `DKQ_OFS_STAT, 32'h0, q);
			i++;
		end while (q[`DKQ_S_READY] !== 1'b1 && i < 40);
		chk(q[`DKQ_S_READY], 1'b1);
	endtask

	task automatic t_keys();
		wr(`DKQ_OFS_K2L, 32'hffff_ffff);
		wr(`DKQ_OFS_K2R, 32'h1234_5678);
		wr(`DKQ_OFS_K3L, 32'h8000_0001);
		wr(`DKQ_OFS_K3R, 32'hffff_ffff);
		wr(`DKQ_OFS_CTRL, 32'h0000_0020);
		rdc(`DKQ_OFS_K2R, 32'h1234_5678);
		chk(core_triple, 1'b1);
		chk(core_key_two, 64'hfefe_fefe_1234_5678);
		chk(core_key_three, 64'h8000_0000_fefe_fefe);
		wr(`DKQ_OFS_CTRL, 32'h0000_0000);
		rdc(`DKQ_OFS_K3L, 32'h8000_0001);
		chk(core_key_two, 64'h0);
		rdc(6'h3c, 32'h0);
		$display("keys test done");
	endtask

	task automatic t_fill();
		logic [31:0] q;
		for (int t = 0; t < 2; t++) begin
			wr(`DKQ_OFS_CTRL, t ? 32'h0000_0280 : 32'h0000_0200);
			for (int n = 1; n < 10; n++) begin
				wr(`DKQ_OFS_INQ, n);
				bus(1'b0, `DKQ_OFS_STAT, 32'h0, q);
				chk(q[`DKQ_S_SPACE], (8 - n) >= (t ? 2 : 4));
				chk(q[`DKQ_S_IN_FULL], n >= 8);
			end
		end
		wr(`DKQ_OFS_CTRL, 32'h0000_0200);
		bus(1'b0, `DKQ_OFS_STAT, 32'h0, q);
		chk(q[`DKQ_S_IN_EMPTY], 1'b1);
		$display("fill test done");
	endtask

	task automatic t_order();
		logic [63:0] r;
		wr(`DKQ_OFS_IVL, 32'hdead_0001);
		wr(`DKQ_OFS_IVR, 32'h0bad_0002);
		for (int o = 0; o < 2; o++) begin
			wr(`DKQ_OFS_CTRL, o ? 32'h0000_0089 : 32'h0000_0081);
			r = o ? 64'h2222_0000_1111_0000 : 64'h1111_0000_2222_0000;
			blk(32'h1111_0000, 32'h2222_0000, r);
			r = r ^ XK;
			rdc(`DKQ_OFS_OUTQ, o ? r[31:0] : r[63:32]);
			rdc(`DKQ_OFS_OUTQ, o ? r[63:32] : r[31:0]);
		end
		$display("order test done");
	endtask

	task automatic t_cbc();
		logic [63:0] r;
		wr(`DKQ_OFS_IVL, 32'h00ff_00ff);
		wr(`DKQ_OFS_IVR, 32'hf0f0_0000);
		wr(`DKQ_OFS_CTRL, 32'h0000_00c1);
		r = 64'h0123_4567_89ab_cdef;
		blk(r[63:32], r[31:0], r ^ 64'h00ff_00ff_f0f0_0000);
		r = r ^ 64'h00ff_00ff_f0f0_0000 ^ XK;
		rdc(`DKQ_OFS_IVL, r[63:32]);
		rdc(`DKQ_OFS_IVR, r[31:0]);
		rdc(`DKQ_OFS_OUTQ, r[63:32]);
		// Chained decrypt: vector applied after the core, next vector is the input
		wr(`DKQ_OFS_CTRL, 32'h0000_02d1);
		blk(32'h1357_9bdf, 32'h2468_ace0, 64'h1357_9bdf_2468_ace0);
		chk(core_decrypt, 1'b1);
		r = 64'h1357_9bdf_2468_ace0 ^ XK ^ r;
		rdc(`DKQ_OFS_OUTQ, r[63:32]);
		rdc(`DKQ_OFS_OUTQ, r[31:0]);
		rdc(`DKQ_OFS_IVL, 32'h1357_9bdf);
		rdc(`DKQ_OFS_IVR, 32'h2468_ace0);
		$display("chain test done");
	endtask

	task automatic t_irq();
		wr(`DKQ_OFS_CTRL, 32'h0000_0281);
		wr(`DKQ_OFS_ICLR, 32'h0000_0111);
		wr(`DKQ_OFS_IEN, 32'h0000_0001);
		// Irq follows the registers one cycle after the write lands
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		blk(32'h0000_0005, 32'h0000_0006, 64'h0000_0005_0000_0006);
		chk(irq, 1'b1);
		wr(`DKQ_OFS_IEN, 32'h0000_0000);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		wr(`DKQ_OFS_IEN, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b1);
		wr(`DKQ_OFS_ICLR, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		chk(irq, 1'b0);
		$display("irq test done");
	endtask

	task automatic t_dma();
		logic [127:0] r;
		int i;
		wr(`DKQ_OFS_CTRL, 32'h0000_0207);
		wr(`DKQ_OFS_CTRL, 32'h0000_0007);
		chk(dma_in_req, 1'b1);
		r = 128'hcafe_0001_beef_0002_0bad_f00d_1357_2468;
		// One four-word burst with the wide threshold: two blocks
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			dma_in_valid <= 1'b1;
			dma_in_data <= r[127 - 32 * k -: 32];
		end
		@(posedge core_clk);
		dma_in_valid <= 1'b0;
		r = r ^ {XK, XK};
		i = 0;
		while (dma_out_req !== 1'b1 && i < 150) begin
			@(posedge core_clk);
			i++;
		end
		chk(dma_out_req, 1'b1);
		for (int k = 0; k < 4; k++) begin
			i = 0;
			do begin
				@(posedge core_clk);
				i++;
			end while (dma_out_valid !== 1'b1 && i < 60);
			chk(dma_out_valid, 1'b1);
			chk(dma_out_data, r[127 - 32 * k -: 32]);
			dma_out_pop <= 1'b1;
			@(posedge core_clk);
			dma_out_pop <= 1'b0;
		end
		repeat (2) @(posedge core_clk);
		chk(dma_out_valid, 1'b0);
		chk(dma_out_req, 1'b0);
		$display("dma test done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d, n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		#40000;
		n_errors++;
		complete_run();
	end

	initial begin
		rst = 1'b1;
		{avs_read, avs_write, dma_in_valid, dma_out_pop} = 4'h0;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		dma_in_data = 32'h0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		t_keys();
		t_fill();
		t_order();
		t_cbc();
		t_irq();
		t_dma();
		complete_run();
	end
endmodule
